/* design/timer16_regs.sv */
// Purpose: 16-bit timer with prescaler, external count, capture, two compares and flags.
// Assumes: APB slave on pclk (10 MHz); pins are asynchronous and are synchronised here.
// Notes: Waveform sequences beyond normal and clear-on-match count up and wrap at top.
// Operation
// R1: With the filter on, capture input changes only after four equal samples.
// R2: Edge select zero triggers on falling edge, one on rising edge.
// R3: Capture copies the counter into the capture register and sets the capture flag.
// R4: When capture register is the top, the capture pin is ignored.
// R5: Software writes zero to reserved bit 5 of capture clock control.
// R6: Clock select zero stops; one to five divide the clock by 1,8,64,256,1024.
// R7: Code six counts falling count-pin edges, seven counts rising edges.
// R8: Count-pin transitions count even when that pin is an output.
// R9: Force strobes act only in non-PWM waveform modes.
// R10: Software writes force bits as zero while a PWM mode is selected.
// R11: A force strobe applies an immediate match to that channel's output.
// R12: A forced match sets no flag, raises no interrupt, and never clears the counter.
// R13: Force bit positions always read zero.
// R14: 16-bit registers transfer the high byte through one shared temporary register. Code: compare high bytes read directly.
// R15: A counter write suppresses compare matches on the next timer clock.
// R16: Compare registers are compared continuously; match drives flag and output.
// R17: Capture source is the capture pin or the analog comparator output.
// R18: Interrupt requested only with enable, global flag and matching flag all set.
// R19: With capture register as top, capture flag sets when counter reaches top.
// R20: Compare flag sets the timer clock after the counter equals the compare value.
// R21: Overflow flag sets on wrap in normal and clear-on-match; else per mode. Code: non-PWM modes set it at 0xffff, not at top.
// R22: Flags clear on vector acknowledge or when one is written to them.
// R23: Non-PWM output modes: 00 off, 01 toggle, 10 clear, 11 set.
// R24: With clock select zero the counter holds and counting sets no flag.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module timer16_regs
  import timer16_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_enable_a,
  output logic wave_enable_b,
  output logic capture_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic overflow_irq
);
  initial begin
    if (COUNT_WIDTH != 16) $error("timer16_regs: only a 16-bit counter is supported");
  end

  logic [7:0] control_a;
  logic [7:0] capture_clock_control;
  logic [7:0] timer_irq_enable;
  logic [7:0] timer_irq_flags;
  logic [7:0] temp_high;
  logic [15:0] counter_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [9:0] prescale;
  logic [2:0] ext_sync;
  logic capture_prev;
  logic suppress_match;
  logic match_a_pending;
  logic match_b_pending;

  // Field decode.
  logic [3:0] waveform_mode;
  clock_select_t clock_select;
  compare_output_mode_t compare_output_mode_a;
  compare_output_mode_t compare_output_mode_b;
  logic capture_filter_enable;
  logic capture_edge_select;
  logic capture_source_comparator;
  assign waveform_mode = {capture_clock_control[4:3], control_a[1:0]};
  assign clock_select = clock_select_t'(capture_clock_control[2:0]);
  assign compare_output_mode_a = compare_output_mode_t'(control_a[7:6]);
  assign compare_output_mode_b = compare_output_mode_t'(control_a[5:4]);
  assign capture_filter_enable = capture_clock_control[`BIT_FILTER_EN];
  assign capture_edge_select = capture_clock_control[`BIT_EDGE_SEL];
  assign capture_source_comparator = control_a[2];

  // Mode classes: normal and the two clear-on-match modes are non-PWM.
  logic non_pwm;
  logic top_is_capture;
  logic top_is_cmp_a;
  logic [15:0] top_value;
  assign non_pwm = (waveform_mode == 4'h0) || (waveform_mode == 4'h4) || (waveform_mode == 4'hc);
  assign top_is_capture = (waveform_mode == 4'h8) || (waveform_mode == 4'ha) ||
                          (waveform_mode == 4'hc) || (waveform_mode == 4'he);
  assign top_is_cmp_a = (waveform_mode == 4'h4) || (waveform_mode == 4'h9) ||
                        (waveform_mode == 4'hb) || (waveform_mode == 4'hf);
  always_comb begin
    unique case (waveform_mode[1:0])
      2'h1: top_value = `TOP_8BIT;
      2'h2: top_value = `TOP_9BIT;
      2'h3: top_value = `TOP_10BIT;
      default: top_value = `COUNT_MAX;
    endcase
    if (top_is_capture) top_value = capture_value;
    else if (top_is_cmp_a) top_value = compare_value_a;
    else if (waveform_mode == 4'h0) top_value = `COUNT_MAX;
  end

  // APB decode: registers sit at four times their index; one wait state.
  logic [7:0] reg_index;
  logic addr_ok;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  assign reg_index = paddr[9:2];
  assign addr_ok = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) && (
    reg_index == `IDX_CONTROL_A || reg_index == `IDX_CAPTURE_CLOCK ||
    reg_index == `IDX_FORCE_COMPARE || reg_index == `IDX_COUNT_LO ||
    reg_index == `IDX_COUNT_HI || reg_index == `IDX_CAPTURE_LO ||
    reg_index == `IDX_CAPTURE_HI || reg_index == `IDX_CMP_A_LO ||
    reg_index == `IDX_CMP_A_HI || reg_index == `IDX_CMP_B_LO ||
    reg_index == `IDX_CMP_B_HI || reg_index == `IDX_IRQ_ENABLE ||
    reg_index == `IDX_IRQ_FLAGS || reg_index == `IDX_VECTOR_ACK);
  assign wr = psel && penable && !pready && pwrite && addr_ok;
  assign rd = psel && penable && !pready && !pwrite && addr_ok;
  assign wbyte = pwdata[7:0];

  // Filtered capture pin.
  logic capture_level;
  capture_filter #(.SAMPLES(`FILTER_SAMPLES)) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_pin),
    .filter_en(capture_filter_enable), // see R1
    .level(capture_level)
  );

  // Comparator output is asynchronous too.
  logic [1:0] comp_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) comp_sync <= 2'h0;
    else comp_sync <= {comp_sync[0], comparator_out};
  end

  logic capture_src;
  logic capture_event;
  assign capture_src = capture_source_comparator ? comp_sync[1] : capture_level; // see R17
  assign capture_event = !top_is_capture && // see R4
    (capture_edge_select ? (capture_src && !capture_prev) // see R2
                         : (!capture_src && capture_prev));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) capture_prev <= 1'b0;
    else capture_prev <= capture_src;
  end

  // Free-running prescaler and count-pin synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 10'h0;
      ext_sync <= 3'h0;
    end else begin
      prescale <= prescale + 10'h1;
      ext_sync <= {ext_sync[1:0], external_count_pin}; // see R8
    end
  end

  logic tick;
  always_comb begin
    unique case (clock_select) // see R6
      clk_stop: tick = 1'b0; // see R24
      clk_div1: tick = 1'b1;
      clk_div8: tick = (prescale[2:0] == 3'h7);
      clk_div64: tick = (prescale[5:0] == 6'h3f);
      clk_div256: tick = (prescale[7:0] == 8'hff);
      clk_div1024: tick = (prescale == 10'h3ff);
      clk_ext_fall: tick = ext_sync[2] && !ext_sync[1]; // see R7
      clk_ext_rise: tick = !ext_sync[2] && ext_sync[1]; // see R7
    endcase
  end

  // Compare equality and wrap point.
  logic eq_a;
  logic eq_b;
  logic at_top;
  assign eq_a = (counter_value == compare_value_a); // see R16
  assign eq_b = (counter_value == compare_value_b);
  assign at_top = (counter_value == top_value);
  logic counter_write;
  assign counter_write = wr && (reg_index == `IDX_COUNT_LO);

  // Counter: counts up, wraps at top; a low-byte write loads the word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) counter_value <= `RESET_WORD;
    else if (counter_write) counter_value <= {temp_high, wbyte}; // see R14
    else if (tick) counter_value <= at_top ? `RESET_WORD : counter_value + 16'h1;
  end

  // A counter write blocks matches on the next timer clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) suppress_match <= 1'b0;
    else if (counter_write) suppress_match <= 1'b1; // see R15
    else if (tick) suppress_match <= 1'b0;
  end

  // A match marks its flag on the next timer clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_pending <= 1'b0;
      match_b_pending <= 1'b0;
    end else if (tick) begin
      match_a_pending <= eq_a && !suppress_match; // see R20
      match_b_pending <= eq_b && !suppress_match;
    end
  end

  // Flag set sources; all but capture need a timer clock.
  logic [7:0] flag_set;
  logic [7:0] flag_clear;
  always_comb begin
    flag_set = 8'h0;
    flag_set[`BIT_CMP_A] = tick && match_a_pending; // see R12
    flag_set[`BIT_CMP_B] = tick && match_b_pending;
    flag_set[`BIT_OVERFLOW] = tick && (non_pwm ? (counter_value == `COUNT_MAX) // see R21
                                               : at_top);
    flag_set[`BIT_CAPTURE] = capture_event || (top_is_capture && tick && at_top); // see R19
    flag_clear = 8'h0;
    if (wr && reg_index == `IDX_IRQ_FLAGS) flag_clear = wbyte; // see R22
    if (wr && reg_index == `IDX_VECTOR_ACK) flag_clear = flag_clear | wbyte; // see R22
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_irq_flags <= `RESET_BYTE;
    else timer_irq_flags <= ((timer_irq_flags & ~flag_clear) | flag_set) & 8'h27;
  end

  // Capture register: hardware capture or software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) capture_value <= `RESET_WORD;
    else if (capture_event) capture_value <= counter_value; // see R3
    else if (wr && reg_index == `IDX_CAPTURE_LO) capture_value <= {temp_high, wbyte};
  end

  // Shared temporary: high writes fill it, counter and capture low reads latch the high byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) temp_high <= `RESET_BYTE;
    else if (wr && (reg_index == `IDX_COUNT_HI || reg_index == `IDX_CAPTURE_HI ||
                    reg_index == `IDX_CMP_A_HI || reg_index == `IDX_CMP_B_HI))
      temp_high <= wbyte; // see R14
    else if (rd && reg_index == `IDX_COUNT_LO) temp_high <= counter_value[15:8];
    else if (rd && reg_index == `IDX_CAPTURE_LO) temp_high <= capture_value[15:8];
  end

  // Control and compare registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a <= `RESET_BYTE;
      capture_clock_control <= `RESET_BYTE;
      timer_irq_enable <= `RESET_BYTE;
      compare_value_a <= `RESET_WORD;
      compare_value_b <= `RESET_WORD;
    end else if (wr) begin
      if (reg_index == `IDX_CONTROL_A) control_a <= wbyte;
      if (reg_index == `IDX_CAPTURE_CLOCK) capture_clock_control <= wbyte & 8'hdf; // see R5
      if (reg_index == `IDX_IRQ_ENABLE) timer_irq_enable <= wbyte & 8'h27;
      if (reg_index == `IDX_CMP_A_LO) compare_value_a <= {temp_high, wbyte};
      if (reg_index == `IDX_CMP_B_LO) compare_value_b <= {temp_high, wbyte};
    end
  end

  // Waveform outputs: real matches and non-PWM force strobes.
  logic force_a;
  logic force_b;
  assign force_a = wr && reg_index == `IDX_FORCE_COMPARE && wbyte[`BIT_FORCE_A] && non_pwm;
  assign force_b = wr && reg_index == `IDX_FORCE_COMPARE && wbyte[`BIT_FORCE_B] && non_pwm;

  function automatic logic apply_match(input compare_output_mode_t m, input logic cur);
    unique case (m) // see R23
      out_off: apply_match = cur;
      out_toggle: apply_match = !cur;
      out_clear: apply_match = 1'b0;
      out_set: apply_match = 1'b1;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      if (force_a || flag_set[`BIT_CMP_A]) // see R9, R11
        wave_out_a <= apply_match(compare_output_mode_a, wave_out_a);
      if (force_b || flag_set[`BIT_CMP_B]) // see R9, R11
        wave_out_b <= apply_match(compare_output_mode_b, wave_out_b);
    end
  end

  // Pin ownership and interrupt requests.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_enable_a <= 1'b0;
      wave_enable_b <= 1'b0;
      capture_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      wave_enable_a <= (compare_output_mode_a != out_off);
      wave_enable_b <= (compare_output_mode_b != out_off);
      capture_irq <= global_irq_enable && timer_irq_enable[`BIT_CAPTURE] && // see R18
                     timer_irq_flags[`BIT_CAPTURE];
      compare_a_irq <= global_irq_enable && timer_irq_enable[`BIT_CMP_A] &&
                       timer_irq_flags[`BIT_CMP_A];
      compare_b_irq <= global_irq_enable && timer_irq_enable[`BIT_CMP_B] &&
                       timer_irq_flags[`BIT_CMP_B];
      overflow_irq <= global_irq_enable && timer_irq_enable[`BIT_OVERFLOW] &&
                      timer_irq_flags[`BIT_OVERFLOW];
    end
  end

  // Read mux; counter and capture high-byte reads return the temporary latched by the low read.
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h0;
    unique case (reg_index)
      `IDX_CONTROL_A: rbyte = control_a;
      `IDX_CAPTURE_CLOCK: rbyte = capture_clock_control;
      `IDX_FORCE_COMPARE: rbyte = 8'h0; // see R13
      `IDX_COUNT_LO: rbyte = counter_value[7:0];
      `IDX_CAPTURE_LO: rbyte = capture_value[7:0];
      `IDX_CMP_A_LO: rbyte = compare_value_a[7:0];
      `IDX_CMP_A_HI: rbyte = compare_value_a[15:8];
      `IDX_CMP_B_LO: rbyte = compare_value_b[7:0];
      `IDX_CMP_B_HI: rbyte = compare_value_b[15:8];
      `IDX_COUNT_HI, `IDX_CAPTURE_HI: rbyte = temp_high;
      `IDX_IRQ_ENABLE: rbyte = timer_irq_enable;
      `IDX_IRQ_FLAGS: rbyte = timer_irq_flags;
      default: rbyte = 8'h0;
    endcase
  end

  // Answer in the access phase: pready registered, high for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata <= (psel && penable && !pready && !pwrite) ? {24'h0, rbyte} : 32'h0;
    end
  end
endmodule // timer16_regs

/* design/timer16_defs.svh */
// Purpose: Offsets, field positions and reset values of the 16-bit timer.
// Assumes: APB byte addresses, one register per aligned 32-bit word.
// Notes: Offsets are register indices; byte address is four times the index.
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

`define IDX_CONTROL_A 8'h80
`define IDX_CAPTURE_CLOCK 8'h81
`define IDX_FORCE_COMPARE 8'h82
`define IDX_COUNT_LO 8'h84
`define IDX_COUNT_HI 8'h85
`define IDX_CAPTURE_LO 8'h86
`define IDX_CAPTURE_HI 8'h87
`define IDX_CMP_A_LO 8'h88
`define IDX_CMP_A_HI 8'h89
`define IDX_CMP_B_LO 8'h8a
`define IDX_CMP_B_HI 8'h8b
`define IDX_IRQ_ENABLE 8'h6f
`define IDX_IRQ_FLAGS 8'h36
`define IDX_VECTOR_ACK 8'h90

`define BIT_FILTER_EN 7
`define BIT_EDGE_SEL 6
`define BIT_RESERVED_B 5
`define BIT_FORCE_A 7
`define BIT_FORCE_B 6
`define BIT_CAPTURE 5
`define BIT_CMP_B 2
`define BIT_CMP_A 1
`define BIT_OVERFLOW 0

`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define COUNT_MAX 16'hffff
`define FILTER_SAMPLES 3'h4
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

`endif

/* design/timer16_pkg.sv */
// Purpose: Shared types for the 16-bit timer block.
// Assumes: Used with timer16_defs.svh.
// Notes: Codes follow the register encodings.
package timer16_pkg;
  typedef enum logic [2:0] {
    clk_stop = 3'h0, clk_div1 = 3'h1, clk_div8 = 3'h2, clk_div64 = 3'h3,
    clk_div256 = 3'h4, clk_div1024 = 3'h5, clk_ext_fall = 3'h6, clk_ext_rise = 3'h7
  } clock_select_t;
  typedef enum logic [1:0] {
    out_off = 2'h0, out_toggle = 2'h1, out_clear = 2'h2, out_set = 2'h3
  } compare_output_mode_t;
endpackage

/* design/capture_filter.sv */
// Purpose: Synchronises a pin and optionally filters it over consecutive samples.
// Assumes: Pin is asynchronous to pclk.
// Notes: Filter output changes only after SAMPLES equal samples.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module capture_filter #(
  parameter int SAMPLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic filter_en,
  output logic level
);
  initial begin
    if (SAMPLES < 2 || SAMPLES > 7) $error("capture_filter: SAMPLES out of range");
  end
  logic sync1;
  logic sync2;
  logic filtered;
  logic [2:0] run;

  // Two flops before any logic looks at the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // Counts samples differing from the held output; resets on any agreeing sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 3'h0;
      filtered <= 1'b0;
    end else if (sync2 == filtered) begin
      run <= 3'h0;
    end else if (run == 3'(SAMPLES - 1)) begin
      run <= 3'h0;
      filtered <= sync2;
    end else begin
      run <= run + 3'h1;
    end
  end

  assign level = filter_en ? filtered : sync2;
endmodule // capture_filter

/* verification/timer16_properties.sv */
// Purpose: Checks on the timer's bus and interrupt request ports.
// Assumes: One wait state; interrupt requests are registered.
// Notes: Bound to every instance of the timer block.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module timer16_checks (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic capture_irq,
  input wire logic compare_a_irq,
  input wire logic compare_b_irq,
  input wire logic overflow_irq
);
  // One clock; quiet during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First access cycle, not yet answered.
  sequence pending;
    psel && penable && !pready;
  endsequence
  sequence taken(w, idx);
    pending ##0 pwrite == w && paddr == {22'h0, idx, 2'b00};
  endsequence

  // One wait state, a one-cycle answer.
  answer_next_a: assert property (pending |=> pready)
    else $error("no answer one cycle into the access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside an access phase");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  force_reads_zero_a: assert property (
    taken(1'b0, `IDX_FORCE_COMPARE) |=> prdata[7:6] == 2'b00)
    else $error("force bits read back nonzero");
  // Registered requests follow the global enable one edge later.
  irq_gated_a: assert property (
    !global_irq_enable |=> !(capture_irq || compare_a_irq || compare_b_irq || overflow_irq))
    else $error("request without global enable");
  flag_clear_a: assert property (
    taken(1'b1, `IDX_IRQ_FLAGS) ##0 pwdata[1] |=> ##[0:2] !compare_a_irq)
    else $error("compare A request survives clear");
  reset_quiet_a: assert property ($rose(presetn) |-> !pready && !capture_irq && !overflow_irq)
    else $error("outputs active after reset");
endmodule // timer16_checks

bind timer16_regs timer16_checks checks (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_irq_enable(global_irq_enable), .capture_irq(capture_irq),
  .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq), .overflow_irq(overflow_irq)
);

/* verification/cpu_bus_model.sv */
// Purpose: Processor-side partner issuing register transfers.
// Assumes: One transfer at a time; the block answers by raising pready.
// Notes: Keeps the software duties on reserved and force bits, judging PWM from control A bits 1:0 only.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module cpu_bus_model (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata
);
  logic pwm_mode;

  // Idle lines during reset.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pwm_mode = 1'b0;
  end

  // Setup, then access until ready; released lines show inverted data.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (wr && idx == `IDX_CAPTURE_CLOCK) v[5] = 1'b0;
    if (wr && idx == `IDX_FORCE_COMPARE && pwm_mode) v[7:6] = 2'b00;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (wr && idx == `IDX_CONTROL_A) pwm_mode = (d[1:0] != 2'b00);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // cpu_bus_model

/* verification/tb_timer16_capture_compare_regs.sv */
// Purpose: Self-checking bench for the 16-bit timer.
// Assumes: The partner model issues all transfers.
// Notes: Timer clock is stopped around checks to keep counts exact.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module tb_timer16_capture_compare_regs;
  typedef struct packed {logic err; logic [7:0] mask; logic [7:0] val;} note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic capture_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic external_count_pin = 1'b0;
  logic global_irq_enable = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic wave_out_a, wave_out_b, wave_enable_a, wave_enable_b;
  logic capture_irq, compare_a_irq, compare_b_irq, overflow_irq;
  note_t notes[$];
  int err_count = 0;
  int samples_checked = 0;
  logic [15:0] v;
  int n;

  // Free-running 10 MHz bus clock.
  always #50 pclk = ~pclk;

  cpu_bus_model cpu (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  timer16_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(capture_pin), .comparator_out(comparator_out),
    .external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_enable_a(wave_enable_a),
    .wave_enable_b(wave_enable_b), .capture_irq(capture_irq),
    .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
    .overflow_irq(overflow_irq));

  task automatic fail(input string what);
    err_count++;
    $display("Error at %0t: %s", $time, what);
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d mismatches in %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each read leaves a note; a zero mask bit marks a don't-care data bit.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [7:0] m = 8'hff, input logic e = 1'b0);
    notes.push_back('{e, m, exp});
    cpu.xfer(1'b0, idx, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cpu.xfer(1'b1, idx, d);
  endtask
  // High byte first into the shared temporary; the low byte commits.
  task automatic wr16(input logic [7:0] idx, input logic [15:0] d);
    wr(idx + 8'h01, d[15:8]);
    wr(idx, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] idx, input logic [15:0] exp);
    rd(idx, exp[7:0]);
    rd(idx + 8'h01, exp[15:8]);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic check_pin(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) fail(what);
  endtask
  task automatic check_read(input note_t nt);
    samples_checked++;
    if (pslverr !== nt.err || ((prdata[7:0] ^ nt.val) & nt.mask) !== 8'h00)
      fail("read data or error flag differs");
  endtask

  // Judge each read when answered, oldest note first.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) fail("read with no expectation");
      else check_read(notes.pop_front());
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(5258));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_FORCE_COMPARE, 8'h00);
    rd(`IDX_CAPTURE_CLOCK, 8'h00);
    rd(8'h00, 8'h00, 8'h00, 1'b1);
    wr(`IDX_CONTROL_A, 8'h40);
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_FORCE_COMPARE, 8'h80);
      settle();
      check_pin(wave_out_a, ~i[0], "forced toggle on channel A");
    end
    check_pin(wave_enable_a, 1'b1, "pin A not driven");
    rd(`IDX_FORCE_COMPARE, 8'h00);
    rd(`IDX_IRQ_FLAGS, 8'h00, 8'h27);
    v = 16'h0020 + 16'($urandom_range(63));
    wr16(`IDX_CMP_A_LO, v);
    wr16(`IDX_CMP_B_LO, v + 16'h0008);
    rd16(`IDX_CMP_B_LO, v + 16'h0008);
    wr16(`IDX_COUNT_LO, 16'h0000);
    repeat (20) @(posedge pclk);
    rd16(`IDX_COUNT_LO, 16'h0000);
    wr(`IDX_IRQ_ENABLE, 8'h27);
    global_irq_enable <= 1'b1;
    wr(`IDX_CAPTURE_CLOCK, 8'h01);
    repeat (120) @(posedge pclk);
    wr(`IDX_CAPTURE_CLOCK, 8'h00);
    rd(`IDX_IRQ_FLAGS, 8'h06, 8'h27);
    settle();
    check_pin(compare_a_irq, 1'b1, "compare A request missing");
    check_pin(compare_b_irq, 1'b1, "compare B request missing");
    @(posedge pclk);
    global_irq_enable <= 1'b0;
    settle();
    check_pin(compare_a_irq, 1'b0, "request without global enable");
    wr(`IDX_IRQ_FLAGS, 8'h02);
    wr(`IDX_VECTOR_ACK, 8'h04);
    rd(`IDX_IRQ_FLAGS, 8'h00, 8'h06);
    wr16(`IDX_COUNT_LO, 16'hfff0);
    wr(`IDX_CAPTURE_CLOCK, 8'h01);
    repeat (30) @(posedge pclk);
    wr(`IDX_CAPTURE_CLOCK, 8'h00);
    rd(`IDX_IRQ_FLAGS, 8'h01, 8'h07);
    wr(`IDX_IRQ_FLAGS, 8'h01);
    global_irq_enable <= 1'b1;
    // With select equal to the idle level, leaving idle is the wrong edge.
    for (int p = 0; p < 2; p++) begin
      capture_pin <= p[0];
      v = 16'($urandom);
      wr16(`IDX_COUNT_LO, v);
      wr(`IDX_CAPTURE_CLOCK, {p[0], p[0], 6'h00});
      capture_pin <= ~p[0];
      repeat (12) @(posedge pclk);
      if (p == 1) begin
        capture_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        capture_pin <= 1'b0;
        repeat (12) @(posedge pclk);
      end
      rd(`IDX_IRQ_FLAGS, 8'h00, 8'h20);
      capture_pin <= p[0];
      repeat (12) @(posedge pclk);
      rd(`IDX_IRQ_FLAGS, 8'h20, 8'h20);
      rd16(`IDX_CAPTURE_LO, v);
      settle();
      check_pin(capture_irq, 1'b1, "capture request missing");
      wr(`IDX_IRQ_FLAGS, 8'h20);
    end
    for (int c = 6; c < 8; c++) begin
      n = 1 + $urandom_range(7);
      wr16(`IDX_COUNT_LO, 16'h0000);
      wr(`IDX_CAPTURE_CLOCK, 8'(c));
      repeat (n) begin
        external_count_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        external_count_pin <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      wr(`IDX_CAPTURE_CLOCK, 8'h00);
      rd16(`IDX_COUNT_LO, 16'(n));
    end
    tally_and_finish();
  end

  // Ends a hung run; the tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    fail("watchdog expired");
    tally_and_finish();
  end
endmodule // tb_timer16_capture_compare_regs
